// ### common/gwb_pkg.sv
// shared constants and types for the 488 to word-serial bridge
// assumes a single core clock domain and an apb register slave
package gwb_pkg;

    // servant population and index width
    localparam int SRV_N = 8;
    localparam int SRV_W = 3;

    // message kinds handed over by the 488 acceptor front end
    localparam logic [2:0] MK_DATA = 3'h0; // data byte, eoi alongside
    localparam logic [2:0] MK_BREQ = 3'h1; // byte request from talker side
    localparam logic [2:0] MK_DCL  = 3'h2; // universal device clear
    localparam logic [2:0] MK_SDC  = 3'h3; // selective device clear
    localparam logic [2:0] MK_GET  = 3'h4; // group execute trigger

    // bit positions in word-serial words and event words
    localparam int END_BIT     = 8;
    localparam int EV_TRUE_BIT = 7;

    // apb register byte addresses
    localparam logic [7:0] A_CTL  = 8'h00; // controlled servants mask
    localparam logic [7:0] A_TRIG = 8'h04; // trigger capable mask
    localparam logic [7:0] A_ALT  = 8'h08; // alternate trigger path mask
    localparam logic [7:0] A_STAT = 8'h0c; // pending requests, rsv, busy

    // register reset values
    localparam logic [7:0] CTL_RST  = 8'hff;
    localparam logic [7:0] TRIG_RST = 8'hff;
    localparam logic [7:0] ALT_RST  = 8'h00;

    // status field positions
    localparam int ST_RSV_BIT  = 8;
    localparam int ST_BUSY_BIT = 9;

    // message sequencer states
    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_SCAN  = 6'h02,
        S_SEND  = 6'h04,
        S_FETCH = 6'h08,
        S_TALK  = 6'h10,
        S_DONE  = 6'h20
    } gwb_state_t;

endpackage : gwb_pkg

// ### src/gwb_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes inputs arrive asynchronously to clk
`timescale 1ns/1ps
module gwb_sync3 import gwb_pkg::*; #(
    parameter int W = 1
) (
    // clock, reset, enable
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    // raw and filtered level
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } gwb_sync_t;

    gwb_sync_t cur;
    gwb_sync_t next_s;

    // shift chain; output follows only where stage two and three agree
    always_comb begin
        next_s    = cur;
        next_s.s1 = d;
        next_s.s2 = cur.s1;
        next_s.s3 = cur.s2;
        for (int i = 0; i < W; i++) begin
            if (cur.s2[i] == cur.s3[i]) begin
                next_s.q[i] = cur.s3[i];
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_s;
        end
    end

    assign q = cur.q;

endmodule : gwb_sync3

// ### src/gwb_bridge.sv
// 488 message to word-serial command bridge with apb configuration
// assumes a same-clock 488 front end handing over decoded messages,
// same-clock word-serial engine, and an asynchronous servant irq line
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// What this block does
// [R1] each data byte goes as byte available to every controlled listener, end mirrors eoi
// [R2] a byte request goes as byte request to the single talking servant
// [R3] the servant answer is fetched by word-serial read before talking
// [R4] talk data carries the answer byte, eoi exactly when its end bit is set
// [R5] byte available and trigger wait on input ready, byte request on output ready
// [R6] device clear sends clear to every controlled servant
// [R7] selective clear sends clear only to controlled servants addressed to listen
// [R8] ndac stays held until the command reached every affected servant
// [R9] no soft reset of any servant is ever issued
// [R10] trigger goes to listeners that are controlled, trigger capable, not alternate
// [R11] messages are forwarded strictly in arrival order, one at a time
// [R12] acceptor, source, talker, listener, service request, clear, trigger per servant
// [R13] parallel poll is not offered by this bridge
// [R14] address mapping lives in the front end, which supplies listen mask and talker
// [R15] the bridge commands its servants with word-serial commands
// [R16] servant events are taken both as signals and as acknowledged interrupts
// [R17] no controller capability is offered by this bridge
// [R18] servants raise both request true and request false events
// [R19] servants place master summary status in status bit six
// [R20] servants keep running their operation when cleared
// [R21] any request true event sets the request service output
// [R22] request service drops only when no servant still has a request pending
// [R23] fan-out goes one servant at a time, done after the last accepts
module gwb_bridge import gwb_pkg::*; #(
    parameter logic [15:0] P_CMD_BAV  = 16'h1000, // arbitrary command codes
    parameter logic [15:0] P_CMD_BREQ = 16'h2000,
    parameter logic [15:0] P_CMD_CLR  = 16'h3000,
    parameter logic [15:0] P_CMD_TRIG = 16'h4000
) (
    // clock, reset, enable
    input  wire logic              CORE_CLK,
    input  wire logic              SRST,
    input  wire logic              CE,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // 488 front end: decoded messages and addressing
    input  wire logic              MSG_VALID,
    input  wire logic [2:0]        MSG_KIND,
    input  wire logic [7:0]        MSG_DATA,
    input  wire logic              MSG_EOI,
    output logic                   MSG_READY,
    output logic                   NDAC_HOLD,
    input  wire logic [SRV_N-1:0]  LISTEN_MASK,
    input  wire logic [SRV_W-1:0]  TALK_ID,
    input  wire logic              TALK_EN,
    // 488 front end: talk data
    output logic                   TALK_VALID,
    output logic      [7:0]        TALK_DATA,
    output logic                   TALK_EOI,
    input  wire logic              TALK_READY,
    output logic                   RSV,
    // word-serial engine
    output logic                   WS_REQ,
    output logic      [SRV_W-1:0]  WS_SERVANT,
    output logic      [15:0]       WS_CMD,
    input  wire logic              WS_ACK,
    output logic                   WS_READ,
    input  wire logic              WS_RESP_VALID,
    input  wire logic [15:0]       WS_RESP,
    // servant ready flags
    input  wire logic [SRV_N-1:0]  SRV_DIR,
    input  wire logic [SRV_N-1:0]  SRV_OUT_READY,
    // servant events
    input  wire logic              SIG_VALID,
    input  wire logic [7:0]        SIG_WORD,
    input  wire logic              SRV_IRQ,
    output logic                   IACK_REQ,
    input  wire logic              IACK_ACK,
    input  wire logic [7:0]        IACK_DATA
);

    typedef struct packed {
        gwb_state_t       st;
        logic [2:0]       kind;
        logic [7:0]       data;
        logic             eoi;
        logic [SRV_N-1:0] targets;
        logic [SRV_W-1:0] idx;
        logic [15:0]      cmd;
        logic             talk_valid;
        logic [7:0]       talk_data;
        logic             talk_eoi;
        logic [SRV_N-1:0] ctl;
        logic [SRV_N-1:0] trig;
        logic [SRV_N-1:0] alt;
        logic [SRV_N-1:0] pending;
        logic             iack_req;
        logic             iack_wait;
        logic [31:0]      prdata;
    } gwb_core_t;

    localparam gwb_core_t RST_VAL = '{st: S_IDLE, ctl: CTL_RST, trig: TRIG_RST,
                                      alt: ALT_RST, default: '0};

    gwb_core_t        cur;
    gwb_core_t        next_s;
    logic             irq_s;
    logic [SRV_N-1:0] new_targets;
    logic             srv_ok;
    logic [15:0]      cmd_word;
    logic [SRV_N-1:0] ev_set;
    logic [SRV_N-1:0] ev_clr;
    logic [SRV_N-1:0] sig_mask;
    logic [SRV_N-1:0] irq_mask;
    logic             ack_take;
    logic             apb_wr;
    logic             apb_mapped;
    logic [31:0]      stat_word;

    // irq pin filtered into the core domain
    gwb_sync3 #(.W(1)) u_irq_sync (
        .clk  (CORE_CLK),
        .srst (SRST),
        .ce   (CE),
        .d    (SRV_IRQ),
        .q    (irq_s)
    );

    // fan-out target set for an incoming message
    always_comb begin
        unique case (MSG_KIND)
            MK_DATA: new_targets = LISTEN_MASK & cur.ctl; // R1
            MK_BREQ: new_targets = (SRV_N'(1) << TALK_ID) & {SRV_N{TALK_EN}} & cur.ctl; // R2 R14
            MK_DCL:  new_targets = cur.ctl; // R6
            MK_SDC:  new_targets = LISTEN_MASK & cur.ctl; // R7
            MK_GET:  new_targets = LISTEN_MASK & cur.ctl & cur.trig & ~cur.alt; // R10
            default: new_targets = '0;
        endcase
    end

    // per-servant readiness and the command word for the current servant
    always_comb begin
        cmd_word = P_CMD_CLR; // clears only, never a soft reset R9
        srv_ok   = 1'b1;
        unique case (cur.kind)
            MK_DATA: begin
                srv_ok            = SRV_DIR[cur.idx]; // R5
                cmd_word          = P_CMD_BAV | 16'(cur.data);
                cmd_word[END_BIT] = cur.eoi; // R1
            end
            MK_BREQ: begin
                srv_ok   = SRV_OUT_READY[cur.idx]; // R5
                cmd_word = P_CMD_BREQ; // R2
            end
            MK_GET: begin
                srv_ok   = SRV_DIR[cur.idx]; // R5
                cmd_word = P_CMD_TRIG; // R10
            end
            default: begin
                srv_ok   = 1'b1;
                cmd_word = P_CMD_CLR; // R6 R7
            end
        endcase
    end

    // request true and false from signals and acknowledged interrupts
    always_comb begin
        ack_take = cur.iack_req & IACK_ACK;
        sig_mask = SRV_N'(1) << SIG_WORD[SRV_W-1:0];
        irq_mask = SRV_N'(1) << IACK_DATA[SRV_W-1:0];
        ev_set   = '0;
        ev_clr   = '0;
        if (SIG_VALID) begin // R16
            if (SIG_WORD[EV_TRUE_BIT]) begin
                ev_set = ev_set | sig_mask;
            end else begin
                ev_clr = ev_clr | sig_mask;
            end
        end
        if (ack_take) begin // R16
            if (IACK_DATA[EV_TRUE_BIT]) begin
                ev_set = ev_set | irq_mask;
            end else begin
                ev_clr = ev_clr | irq_mask;
            end
        end
    end

    // apb decode and status word
    always_comb begin
        apb_wr     = PSEL & PENABLE & PWRITE;
        apb_mapped = (PADDR == A_CTL) || (PADDR == A_TRIG) || (PADDR == A_ALT) || (PADDR == A_STAT);
        stat_word  = '0;
        stat_word[SRV_N-1:0]  = cur.pending;
        stat_word[ST_RSV_BIT]  = |cur.pending;
        stat_word[ST_BUSY_BIT] = (cur.st != S_IDLE);
    end

    // next state of the whole block
    always_comb begin
        next_s = cur;
        // request tracking per servant, set wins over clear R22
        next_s.pending = (cur.pending & ~ev_clr) | ev_set; // R21 R22
        // interrupt handler: one acknowledge per irq assertion
        if (ack_take) begin
            next_s.iack_req  = 1'b0;
            next_s.iack_wait = 1'b1;
        end else if (irq_s && !cur.iack_req && !cur.iack_wait) begin
            next_s.iack_req = 1'b1; // R16
        end
        if (!irq_s && !cur.iack_req) begin
            next_s.iack_wait = 1'b0;
        end
        // apb read data captured in the setup cycle
        if (PSEL && !PENABLE) begin
            unique case (PADDR)
                A_CTL:   next_s.prdata = 32'(cur.ctl);
                A_TRIG:  next_s.prdata = 32'(cur.trig);
                A_ALT:   next_s.prdata = 32'(cur.alt);
                A_STAT:  next_s.prdata = stat_word;
                default: next_s.prdata = '0;
            endcase
        end
        // apb writes take effect in the access cycle
        if (apb_wr) begin
            unique case (PADDR)
                A_CTL:   next_s.ctl  = PWDATA[SRV_N-1:0];
                A_TRIG:  next_s.trig = PWDATA[SRV_N-1:0];
                A_ALT:   next_s.alt  = PWDATA[SRV_N-1:0];
                default: next_s.ctl  = cur.ctl;
            endcase
        end
        // message sequencer, one message in flight R11
        unique case (cur.st)
            S_IDLE: begin
                if (MSG_VALID) begin
                    next_s.kind    = MSG_KIND;
                    next_s.data    = MSG_DATA;
                    next_s.eoi     = MSG_EOI;
                    next_s.targets = new_targets;
                    next_s.idx     = '0;
                    next_s.st      = S_SCAN;
                end
            end
            S_SCAN: begin
                if (cur.targets == '0) begin
                    next_s.st = S_DONE; // R23
                end else if (!cur.targets[cur.idx]) begin
                    next_s.idx = cur.idx + 1'b1;
                end else if (srv_ok) begin // R5
                    next_s.cmd = cmd_word; // R15
                    next_s.st  = S_SEND;
                end
            end
            S_SEND: begin
                if (WS_ACK) begin
                    next_s.targets[cur.idx] = 1'b0; // R23
                    if (cur.kind == MK_BREQ) begin
                        next_s.st = S_FETCH; // R3
                    end else begin
                        next_s.idx = cur.idx + 1'b1;
                        next_s.st  = S_SCAN;
                    end
                end
            end
            S_FETCH: begin
                if (WS_RESP_VALID) begin
                    next_s.talk_data  = WS_RESP[7:0]; // R4
                    next_s.talk_eoi   = WS_RESP[END_BIT]; // R4
                    next_s.talk_valid = 1'b1;
                    next_s.st         = S_TALK;
                end
            end
            S_TALK: begin
                if (TALK_READY) begin
                    next_s.talk_valid = 1'b0;
                    next_s.st         = S_DONE;
                end
            end
            S_DONE: begin
                next_s.st = S_IDLE;
            end
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cur <= RST_VAL;
        end else if (CE) begin
            cur <= next_s;
        end
    end

    // outputs
    assign PRDATA     = cur.prdata;
    assign PREADY     = CE;
    assign PSLVERR    = PSEL & PENABLE & ~apb_mapped;
    assign MSG_READY  = (cur.st == S_DONE); // R11
    assign NDAC_HOLD  = MSG_VALID & (cur.st != S_DONE); // R8 R12
    assign TALK_VALID = cur.talk_valid;
    assign TALK_DATA  = cur.talk_data;
    assign TALK_EOI   = cur.talk_eoi;
    assign RSV        = |cur.pending; // R21
    assign WS_REQ     = (cur.st == S_SEND);
    assign WS_SERVANT = cur.idx;
    assign WS_CMD     = cur.cmd;
    assign WS_READ    = (cur.st == S_FETCH);
    assign IACK_REQ   = cur.iack_req;
    // no parallel poll response and no controller outputs exist here R13 R17

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    bav_end_a: assert property (WS_REQ && cur.kind == MK_DATA |-> WS_CMD[END_BIT] == cur.eoi) // R1
        else $error("byte available end differs from eoi");
    talk_eoi_a: assert property ($rose(TALK_VALID) |-> TALK_EOI == $past(WS_RESP[END_BIT])) // R4
        else $error("talk eoi differs from response end");
    fetch_first_a: assert property ($rose(TALK_VALID) |-> $past(cur.st == S_FETCH)) // R3
        else $error("talk data without fetch");
    dir_gate_a: assert property ($rose(WS_REQ) && cur.kind != MK_BREQ && cur.kind != MK_DCL
                                 && cur.kind != MK_SDC |-> $past(SRV_DIR[cur.idx])) // R5
        else $error("command sent to servant not input ready");
    ordy_gate_a: assert property ($rose(WS_REQ) && cur.kind == MK_BREQ |-> $past(SRV_OUT_READY[cur.idx])) // R5
        else $error("byte request to servant not output ready");
    ctl_only_a: assert property (WS_REQ |-> cur.ctl[WS_SERVANT]) // R6
        else $error("command to uncontrolled servant");
    trig_sel_a: assert property (WS_REQ && cur.kind == MK_GET
                                 |-> cur.trig[WS_SERVANT] && !cur.alt[WS_SERVANT]) // R10
        else $error("trigger to excluded servant");
    fanout_done_a: assert property (MSG_READY |-> cur.targets == '0 && !WS_REQ) // R8
        else $error("message released before fan-out ended");
    ready_once_a: assert property (MSG_READY |=> !MSG_READY) // R11
        else $error("message ready longer than one cycle");
    rsv_set_a: assert property (CE && SIG_VALID && SIG_WORD[EV_TRUE_BIT] |=> RSV) // R21
        else $error("request true did not raise rsv");

    bav_end_c: cover property (WS_REQ && WS_ACK && cur.kind == MK_DATA && cur.eoi);
    breq_c: cover property (TALK_VALID && TALK_READY);
    get_c: cover property (MSG_READY && cur.kind == MK_GET);

endmodule : gwb_bridge

// ### tb/gwb_srv_model.sv
// behavioural servant side of the word-serial engine: acks commands, answers reads
// assumes the bridge holds its request until ack and reads until resp valid
`timescale 1ns/1ps
module gwb_srv_model import gwb_pkg::*; (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // command path
    input  wire logic             ws_req,
    input  wire logic [SRV_W-1:0] ws_servant,
    input  wire logic [15:0]      ws_cmd,
    output logic                  ws_ack,
    // response path
    input  wire logic             ws_read,
    output logic                  ws_resp_valid,
    output logic      [15:0]      ws_resp
);
    int          ack_wait = 0;
    int          cnt      = 0;
    int          nread    = 0;
    logic [15:0] resp_word [SRV_N];
    logic [18:0] log_q [$];

    // accept one command per request, optionally slow; answers the pending byte request read
    always @(posedge clk) begin
        ws_ack        <= 1'b0;
        ws_resp_valid <= 1'b0;
        ws_resp       <= ~ws_resp; // released bus inverts every cycle, so the old answer returns every other cycle
        if (srst) begin
            cnt = 0;
        end else if ((ws_req && !ws_ack) || (ws_read && !ws_resp_valid)) begin
            if (cnt >= ack_wait) begin
                cnt = 0;
                if (ws_req) begin
                    ws_ack <= 1'b1;
                    log_q.push_back({ws_servant, ws_cmd}); // clear only logged, operation undisturbed
                end else begin
                    ws_resp_valid <= 1'b1;
                    ws_resp       <= resp_word[ws_servant]; // status answers keep summary in bit six
                    nread++;
                end
            end else begin
                cnt++;
            end
        end
    end
endmodule : gwb_srv_model

// ### tb/gwb_bridge_tb.sv
// self-checking bench for the 488 to word-serial bridge
// assumes the servant model answers the word-serial side; bench plays front end and apb master
`timescale 1ns/1ps
module gwb_bridge_tb import gwb_pkg::*; ;
    // command codes handed to the bridge, arbitrary values
    localparam logic [15:0] C_BAV = 16'h1000, C_BREQ = 16'h2000, C_CLR = 16'h3000, C_TRIG = 16'h4000;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, msg_valid = 0, msg_eoi = 0, talk_en = 0;
    logic [7:0] paddr = 0, msg_data = 0, listen = 0, srv_dir = 8'hff, srv_ordy = 8'hff, sig_word = 0, iack_data = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0] msg_kind = 0, talk_id = 0;
    logic talk_ready = 0, sig_valid = 0, srv_irq = 0, iack_ack = 0, e, nd_ok;
    logic pready, pslverr, msg_ready, ndac_hold, talk_valid, talk_eoi, rsv, ws_req, ws_ack, ws_read, ws_rv, iack_req;
    logic [7:0] talk_data;
    logic [8:0] talk_got;
    logic [2:0] ws_srv;
    logic [15:0] ws_cmd, ws_resp;
    logic [18:0] exp_q [$];
    int err_total = 0, total_checks = 0, mid_cnt, reads_at_talk;

    always #20 clk = ~clk;

    gwb_bridge #(.P_CMD_BAV(C_BAV), .P_CMD_BREQ(C_BREQ), .P_CMD_CLR(C_CLR), .P_CMD_TRIG(C_TRIG)) u_dut (
        .CORE_CLK(clk), .SRST(srst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MSG_VALID(msg_valid), .MSG_KIND(msg_kind), .MSG_DATA(msg_data), .MSG_EOI(msg_eoi),
        .MSG_READY(msg_ready), .NDAC_HOLD(ndac_hold), .LISTEN_MASK(listen), .TALK_ID(talk_id),
        .TALK_EN(talk_en), .TALK_VALID(talk_valid), .TALK_DATA(talk_data), .TALK_EOI(talk_eoi),
        .TALK_READY(talk_ready), .RSV(rsv), .WS_REQ(ws_req), .WS_SERVANT(ws_srv), .WS_CMD(ws_cmd),
        .WS_ACK(ws_ack), .WS_READ(ws_read), .WS_RESP_VALID(ws_rv), .WS_RESP(ws_resp), .SRV_DIR(srv_dir),
        .SRV_OUT_READY(srv_ordy), .SIG_VALID(sig_valid), .SIG_WORD(sig_word), .SRV_IRQ(srv_irq),
        .IACK_REQ(iack_req), .IACK_ACK(iack_ack), .IACK_DATA(iack_data));

    gwb_srv_model u_srv (.clk(clk), .srst(srst), .ws_req(ws_req), .ws_servant(ws_srv), .ws_cmd(ws_cmd),
        .ws_ack(ws_ack), .ws_read(ws_read), .ws_resp_valid(ws_rv), .ws_resp(ws_resp));

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) err_total++;
        rd = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask : apb

    // hold one decoded message until consumed; releases not-ready servants after ten cycles
    task automatic send_msg(input logic [2:0] k, input logic [7:0] d, input logic eoi);
        int n;
        nd_ok = 1; talk_got = '0; mid_cnt = -1; reads_at_talk = -1;
        msg_valid <= 1; msg_kind <= k; msg_data <= d; msg_eoi <= eoi; talk_ready <= 1;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (msg_ready === 1'b1) break;
            if (ndac_hold !== 1'b1) nd_ok = 0;
            if (talk_valid === 1'b1) begin
                talk_got = {talk_eoi, talk_data};
                reads_at_talk = u_srv.nread;
            end
            if (n == 10) begin
                mid_cnt = u_srv.log_q.size();
                srv_dir <= 8'hff; srv_ordy <= 8'hff;
            end
        end
        if (n == 400) err_total++;
        msg_valid <= 0; msg_data <= ~d; msg_eoi <= ~eoi; talk_ready <= 0;
        @(posedge clk);
    endtask : send_msg

    // compare the commands the servants accepted against the expected list, in order
    task automatic chk_log;
        chk(u_srv.log_q.size(), exp_q.size());
        foreach (exp_q[i]) if (i < u_srv.log_q.size()) chk(u_srv.log_q[i], exp_q[i]);
        exp_q.delete(); u_srv.log_q.delete();
    endtask : chk_log

    task automatic t_regs;
        apb(0, A_CTL, 0);  chk(rd, 32'h0000_00ff);
        apb(0, A_TRIG, 0); chk(rd, 32'h0000_00ff);
        apb(0, A_ALT, 0);  chk(rd, 32'h0000_0000);
        apb(1, A_STAT, 32'h3ff); apb(0, A_STAT, 0); chk(rd, 32'h0);
        apb(1, 8'h10, 32'hffff_ffff); chk(e, 1); apb(0, 8'h10, 0); chk(e, 1); chk(rd, 32'h0);
        $display("test regs done");
    endtask : t_regs

    // data with and without eoi around a trigger, one listener stalled, slow acks
    task automatic t_data;
        listen <= 8'h25; srv_dir <= 8'hfb; u_srv.ack_wait = 2;
        send_msg(MK_DATA, 8'h5a, 1); chk(mid_cnt, 1);
        exp_q = '{{3'd0, C_BAV | 16'h015a}, {3'd2, C_BAV | 16'h015a}, {3'd5, C_BAV | 16'h015a}};
        send_msg(MK_GET, 8'h00, 0);
        exp_q.push_back({3'd0, C_TRIG}); exp_q.push_back({3'd2, C_TRIG}); exp_q.push_back({3'd5, C_TRIG});
        send_msg(MK_DATA, 8'hc3, 0);
        exp_q.push_back({3'd0, C_BAV | 16'h00c3}); exp_q.push_back({3'd2, C_BAV | 16'h00c3});
        exp_q.push_back({3'd5, C_BAV | 16'h00c3});
        chk_log;
        u_srv.ack_wait = 0;
        $display("test data done");
    endtask : t_data

    task automatic t_clear;
        apb(1, A_CTL, 32'h0f); listen <= 8'h00;
        send_msg(MK_DCL, 8'h00, 0); chk(nd_ok, 1);
        exp_q = '{{3'd0, C_CLR}, {3'd1, C_CLR}, {3'd2, C_CLR}, {3'd3, C_CLR}};
        chk_log;
        listen <= 8'h16;
        send_msg(MK_SDC, 8'h00, 0); chk(nd_ok, 1);
        exp_q = '{{3'd1, C_CLR}, {3'd2, C_CLR}};
        chk_log;
        apb(1, A_CTL, 32'hff);
        $display("test clear done");
    endtask : t_clear

    task automatic t_trig;
        apb(1, A_TRIG, 32'hf0); apb(1, A_ALT, 32'h30); listen <= 8'hd9; srv_dir <= 8'h7f;
        send_msg(MK_GET, 8'h00, 0); chk(nd_ok, 1);
        chk(mid_cnt, 1);
        exp_q = '{{3'd6, C_TRIG}, {3'd7, C_TRIG}};
        chk_log;
        $display("test trig done");
    endtask : t_trig

    task automatic t_breq;
        talk_id <= 3'd3; talk_en <= 1; srv_ordy <= 8'h00; u_srv.nread = 0;
        u_srv.resp_word[3] = 16'h01a5;
        send_msg(MK_BREQ, 8'h00, 0); chk(mid_cnt, 0);
        chk(talk_got, 9'h1a5);
        chk(reads_at_talk, 1);
        u_srv.resp_word[3] = 16'h003c;
        send_msg(MK_BREQ, 8'h00, 0); chk(talk_got, 9'h03c);
        exp_q = '{{3'd3, C_BREQ}, {3'd3, C_BREQ}};
        chk_log;
        talk_en <= 0;
        $display("test breq done");
    endtask : t_breq

    // one signal event, then let it land
    task automatic sig(input logic [7:0] w);
        sig_valid <= 1; sig_word <= w;
        @(posedge clk);
        sig_valid <= 0; sig_word <= ~w;
        repeat (2) @(posedge clk);
    endtask : sig

    // one interrupt, acknowledged with the event word
    task automatic irq(input logic [7:0] w);
        int n;
        srv_irq <= 1;
        for (n = 0; n < 30; n++) begin
            @(posedge clk);
            if (iack_req === 1'b1) break;
        end
        chk(n < 30, 1);
        iack_ack <= 1; iack_data <= w; srv_irq <= 0;
        @(posedge clk);
        iack_ack <= 0; iack_data <= ~w;
        repeat (10) @(posedge clk);
    endtask : irq

    task automatic t_events;
        sig(8'h81); chk(rsv, 1);
        sig(8'h84); sig(8'h01); chk(rsv, 1);
        apb(0, A_STAT, 0); chk(rd, 32'h0000_0110);
        sig(8'h04); chk(rsv, 0);
        irq(8'h82); chk(rsv, 1);
        irq(8'h02); chk(rsv, 0);
        $display("test events done");
    endtask : t_events

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out;
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        t_regs;
        t_data;
        t_clear;
        t_trig;
        t_breq;
        t_events;
        close_out;
    end
endmodule : gwb_bridge_tb
